// [hdl/mbr_consts.vh]
// Constants for the field-bus read-function responder.
`ifndef MBR_CONSTS_VH
`define MBR_CONSTS_VH

// ----------------------------------------------------------------------------
// Function codes and exception codes
// ----------------------------------------------------------------------------
`define MBR_FC_DISCRETE   8'h02
`define MBR_FC_HOLDING    8'h03
`define MBR_FC_INPUT_REG  8'h04
`define MBR_FC_COIL       8'h05
`define MBR_EXC_FLAG      8'h80
`define MBR_EXC_FUNC      8'h01
`define MBR_EXC_ADDR      8'h02
`define MBR_EXC_VALUE     8'h03

// ----------------------------------------------------------------------------
// Station numbers and frame layout
// ----------------------------------------------------------------------------
`define MBR_BROADCAST     8'h00
`define MBR_STATION_MIN   8'h01
`define MBR_STATION_MAX   8'hF7
`define MBR_REQ_LEN       3'h6
`define MBR_HDR_LEN       8'h03
`define MBR_COIL_RSP_LEN  8'h06

// ----------------------------------------------------------------------------
// Address space limits
// ----------------------------------------------------------------------------
`define MBR_DI_POINTS     17'h00020
`define MBR_REG_SPACE     17'h00100
`define MBR_REG_MAX       16'h007D
`define MBR_COIL_COUNT    16'h0010
`define MBR_COIL_ON       16'hFF00
`define MBR_COIL_OFF      16'h0000

`endif

// [hdl/mbr_req_rx.v]
// Request collector: gathers the six fixed bytes of a request frame.
`timescale 1ns/1ps
`include "mbr_consts.vh"

module mbr_req_rx (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        rx_start,
  input  wire        rx_valid,
  input  wire [7:0]  rx_data,
  output reg         req_valid,
  output reg  [7:0]  req_station,
  output reg  [7:0]  req_func,
  output reg  [15:0] req_addr,
  output reg  [15:0] req_word
);

  reg [2:0] idx;

  // Bytes past the sixth are dropped until the next frame start.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      idx         <= 3'h0;
      req_valid   <= 1'b0;
      req_station <= 8'h00;
      req_func    <= 8'h00;
      req_addr    <= 16'h0000;
      req_word    <= 16'h0000;
    end else begin
      req_valid <= 1'b0;
      if (rx_start) begin
        idx <= 3'h0;
      end else if (rx_valid && idx != `MBR_REQ_LEN) begin
        idx <= idx + 3'h1;
        case (idx)
          3'h0: req_station <= rx_data;
          3'h1: req_func <= rx_data;
          3'h2: req_addr[15:8] <= rx_data;
          3'h3: req_addr[7:0] <= rx_data;
          3'h4: req_word[15:8] <= rx_data;
          3'h5: begin
            req_word[7:0] <= rx_data;
            req_valid     <= 1'b1;
          end
          default: idx <= idx;
        endcase
      end
    end
  end

endmodule // mbr_req_rx

// [hdl/mbr_responder.v]
// Read-function responder: decodes requests and streams normal or exception replies.
`timescale 1ns/1ps
`include "mbr_consts.vh"

module mbr_responder (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire [7:0]  own_station,
  input  wire        rx_start,
  input  wire        rx_valid,
  input  wire [7:0]  rx_data,
  input  wire [31:0] discrete_input,
  input  wire [15:0] word_rd_data,
  input  wire        tx_ready,
  output reg         tx_valid,
  output reg  [7:0]  tx_data,
  output reg         tx_last,
  output reg         word_rd_en,
  output reg         word_rd_input,
  output reg  [15:0] word_rd_addr,
  output reg  [15:0] coil_state,
  output reg         busy
);

  // --------------------------------------------------------------------------
  // States
  // --------------------------------------------------------------------------
  localparam ST_IDLE  = 2'b00;
  localparam ST_SEND  = 2'b01;
  localparam ST_FETCH = 2'b10;
  localparam ST_WAIT  = 2'b11;

  wire        req_valid;
  wire [7:0]  req_station;
  wire [7:0]  req_func;
  wire [15:0] req_addr;
  wire [15:0] req_word;

  reg  [1:0]  st;
  reg  [7:0]  func;
  reg  [15:0] addr;
  reg  [15:0] cnt;
  reg  [7:0]  exc;
  reg  [7:0]  len;
  reg  [7:0]  pos;
  reg  [15:0] word_buf;
  reg         word_ok;

  reg  [7:0]  next_exc;
  reg  [7:0]  next_len;
  reg  [7:0]  next_byte;
  reg  [16:0] span;
  wire [7:0]  k;
  wire        own_ok;
  wire        addressed;
  wire        is_reg;
  wire        need_word;

  mbr_req_rx u_rx (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .rx_start    (rx_start),
    .rx_valid    (rx_valid),
    .rx_data     (rx_data),
    .req_valid   (req_valid),
    .req_station (req_station),
    .req_func    (req_func),
    .req_addr    (req_addr),
    .req_word    (req_word)
  );

  // --------------------------------------------------------------------------
  // Discrete byte picker
  // --------------------------------------------------------------------------
  // Bits past the requested point count are sent as zero so that the master
  // never sees inputs it did not ask for in the padded last byte.
  function [7:0] di_pick;
    input [31:0] bits;
    input [15:0] start;
    input [15:0] points;
    input [7:0]  idx;
    reg   [31:0] sh;
    reg   [15:0] first;
    integer      i;
    begin
      first = {5'h00, idx, 3'h0};
      sh    = bits >> (start[5:0] + first[5:0]);
      for (i = 0; i < 8; i = i + 1) begin
        di_pick[i] = sh[i] & ((first + i[15:0]) < points);
      end
    end
  endfunction

  assign own_ok    = (own_station >= `MBR_STATION_MIN) && (own_station <= `MBR_STATION_MAX);
  assign addressed = own_ok && (req_station == own_station);
  assign is_reg    = (func == `MBR_FC_HOLDING) || (func == `MBR_FC_INPUT_REG);
  assign k         = pos - `MBR_HDR_LEN;
  assign need_word = is_reg && (exc == 8'h00) && (pos >= `MBR_HDR_LEN) && !k[0] && !word_ok;

  // --------------------------------------------------------------------------
  // Request check and reply length
  // --------------------------------------------------------------------------
  always @* begin
    next_exc = 8'h00;
    next_len = `MBR_HDR_LEN;
    span     = {1'b0, req_addr} + {1'b0, req_word};
    case (req_func)
      `MBR_FC_DISCRETE: begin
        if (req_word == 16'h0000 || {1'b0, req_word} > `MBR_DI_POINTS)
          next_exc = `MBR_EXC_VALUE;
        else if (span > `MBR_DI_POINTS)
          next_exc = `MBR_EXC_ADDR;
        next_len = `MBR_HDR_LEN + req_word[10:3] + {7'h00, |req_word[2:0]};
      end
      `MBR_FC_HOLDING, `MBR_FC_INPUT_REG: begin
        if (req_word == 16'h0000 || req_word > `MBR_REG_MAX)
          next_exc = `MBR_EXC_VALUE;
        else if (span > `MBR_REG_SPACE)
          next_exc = `MBR_EXC_ADDR;
        next_len = `MBR_HDR_LEN + {req_word[6:0], 1'b0};
      end
      `MBR_FC_COIL: begin
        if (req_word != `MBR_COIL_ON && req_word != `MBR_COIL_OFF)
          next_exc = `MBR_EXC_VALUE;
        else if (req_addr >= `MBR_COIL_COUNT)
          next_exc = `MBR_EXC_ADDR;
        next_len = `MBR_COIL_RSP_LEN;
      end
      default: begin
        next_exc = `MBR_EXC_FUNC;
      end
    endcase
    if (next_exc != 8'h00)
      next_len = `MBR_HDR_LEN;
  end

  // --------------------------------------------------------------------------
  // Reply byte selection
  // --------------------------------------------------------------------------
  always @* begin
    next_byte = 8'h00;
    case (pos)
      8'h00: next_byte = own_station;
      8'h01: next_byte = (exc != 8'h00) ? (func | `MBR_EXC_FLAG) : func;
      8'h02: begin
        if (exc != 8'h00)
          next_byte = exc;
        else if (func == `MBR_FC_COIL)
          next_byte = addr[15:8];
        else
          next_byte = len - `MBR_HDR_LEN;
      end
      default: begin
        if (func == `MBR_FC_COIL) begin
          case (pos)
            8'h03: next_byte = addr[7:0];
            8'h04: next_byte = cnt[15:8];
            default: next_byte = cnt[7:0];
          endcase
        end else if (is_reg) begin
          next_byte = k[0] ? word_buf[7:0] : word_buf[15:8];
        end else begin
          next_byte = di_pick(discrete_input, addr, cnt, k);
        end
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------------
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st            <= ST_IDLE;
      func          <= 8'h00;
      addr          <= 16'h0000;
      cnt           <= 16'h0000;
      exc           <= 8'h00;
      len           <= 8'h00;
      pos           <= 8'h00;
      word_buf      <= 16'h0000;
      word_ok       <= 1'b0;
      tx_valid      <= 1'b0;
      tx_data       <= 8'h00;
      tx_last       <= 1'b0;
      word_rd_en    <= 1'b0;
      word_rd_input <= 1'b0;
      word_rd_addr  <= 16'h0000;
      coil_state    <= 16'h0000;
      busy          <= 1'b0;
    end else begin
      case (st)
        ST_IDLE: begin
          // Requests that complete while a reply is streaming are dropped.
          if (req_valid && (addressed || req_station == `MBR_BROADCAST)) begin
            if (req_func == `MBR_FC_COIL && next_exc == 8'h00)
              coil_state[req_addr[3:0]] <= (req_word == `MBR_COIL_ON);
            if (addressed) begin
              func    <= req_func;
              addr    <= req_addr;
              cnt     <= req_word;
              exc     <= next_exc;
              len     <= next_len;
              pos     <= 8'h00;
              word_ok <= 1'b0;
              busy    <= 1'b1;
              st      <= ST_SEND;
            end
          end
        end
        ST_SEND: begin
          if (!tx_valid || tx_ready) begin
            if (pos == len) begin
              tx_valid <= 1'b0;
              tx_last  <= 1'b0;
              busy     <= 1'b0;
              st       <= ST_IDLE;
            end else if (need_word) begin
              tx_valid      <= 1'b0;
              tx_last       <= 1'b0;
              word_rd_en    <= 1'b1;
              word_rd_input <= (func == `MBR_FC_INPUT_REG);
              word_rd_addr  <= addr + {9'h000, k[7:1]};
              st            <= ST_FETCH;
            end else begin
              tx_data  <= next_byte;
              tx_valid <= 1'b1;
              tx_last  <= (pos == len - 8'h01);
              pos      <= pos + 8'h01;
              if (is_reg && k[0])
                word_ok <= 1'b0;
            end
          end
        end
        ST_FETCH: begin
          word_rd_en <= 1'b0;
          st         <= ST_WAIT;
        end
        ST_WAIT: begin
          word_buf <= word_rd_data;
          word_ok  <= 1'b1;
          st       <= ST_SEND;
        end
        default: begin
          st <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // mbr_responder

// [verification/mbr_monitor.sv]
// Checker for the read-function responder ports.
`timescale 1ns/1ps
module mbr_monitor (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic [7:0]  own_station,
  input wire logic        rx_start,
  input wire logic        rx_valid,
  input wire logic [7:0]  rx_data,
  input wire logic        tx_ready,
  input wire logic        tx_valid,
  input wire logic [7:0]  tx_data,
  input wire logic        tx_last,
  input wire logic        word_rd_en,
  input wire logic [15:0] coil_state,
  input wire logic        busy
);
  logic [2:0] rx_idx;
  logic [1:0] tx_idx;
  logic [7:0] req_st;
  wire        six = rx_valid && !rx_start && rx_idx == 3'h5;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_idx <= 3'h0;
      tx_idx <= 2'h0;
      req_st <= 8'h00;
    end else begin
      if (rx_start)
        rx_idx <= 3'h0;
      else if (rx_valid && rx_idx != 3'h6)
        rx_idx <= rx_idx + 3'h1;
      if (rx_valid && !rx_start && rx_idx == 3'h0)
        req_st <= rx_data;
      if (tx_valid && tx_ready)
        tx_idx <= tx_last ? 2'h0 : tx_idx + {1'b0, tx_idx != 2'h3};
    end
  end
  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  chk_first_station: assert property (
    tx_valid && tx_idx == 2'h0 |-> tx_data == own_station)
    else $error("reply does not open with own station");
  // The first reply byte is loaded on the edge after the idle state decodes the request,
  // so it is first sampled three edges after the sixth byte.
  chk_reply_start: assert property (six && !busy |-> ##3
    tx_valid == (req_st == own_station && own_station != 8'h00 && own_station < 8'hF8))
    else $error("reply start does not follow station match");
  chk_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("reply byte changed while stalled");
  chk_rd_pulse: assert property (word_rd_en |=> !word_rd_en)
    else $error("word fetch longer than one cycle");
  chk_rd_fetch: assert property (word_rd_en |-> !tx_valid [*3] ##1 tx_valid)
    else $error("fetched word not offered three cycles later");
  chk_busy_tx: assert property (tx_valid |-> busy)
    else $error("reply byte offered while idle");
  chk_reply_end: assert property (tx_valid && tx_ready && tx_last |=> !tx_valid && !busy)
    else $error("reply does not end after final byte");
  chk_coil_cause: assert property (
    $changed(coil_state) && !$past(sys_rst) |-> $past(six, 2))
    else $error("coils changed without a request");
endmodule // mbr_monitor

bind mbr_responder mbr_monitor u_mon (.clk(clk), .sys_rst(sys_rst),
  .own_station(own_station), .rx_start(rx_start), .rx_valid(rx_valid), .rx_data(rx_data),
  .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
  .word_rd_en(word_rd_en), .coil_state(coil_state), .busy(busy));

// [verification/mbr_master.sv]
// Field-bus master model: sends request frames and collects reply bytes.
`timescale 1ns/1ps
module mbr_master (
  input  wire logic       clk,
  output logic            rx_start,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_last,
  output logic            tx_ready
);
  logic [8:0] rsp[$];
  bit         slow = 1'b0;
  initial begin
    rx_start = 1'b0;
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    tx_ready = 1'b0;
  end
  // A slow master stalls at random so that held reply bytes are exercised.
  always @(posedge clk) begin
    tx_ready <= slow ? 1'($urandom_range(1)) : 1'b1;
    if (tx_valid && tx_ready)
      rsp.push_back({tx_last, tx_data});
  end
  // Station, function, then two 16-bit fields high byte first.
  task automatic send(input logic [47:0] f);
    @(posedge clk);
    rx_start <= 1'b1;
    for (int i = 5; i >= 0; i--) begin
      @(posedge clk);
      rx_start <= 1'b0;
      rx_valid <= 1'b1;
      rx_data  <= f[8*i +: 8];
    end
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_data  <= ~f[7:0];
  endtask
endmodule // mbr_master

// [verification/tb_top.sv]
// Self-checking bench for the read-function responder.
`timescale 1ns/1ps
module tb_top;
  logic        clk, sys_rst, rx_start, rx_valid, tx_ready, tx_valid, tx_last;
  logic        word_rd_en, word_rd_input, busy;
  logic [7:0]  own_station, rx_data, tx_data, st, fc;
  logic [15:0] word_rd_data, word_rd_addr, coil_state, coil_e;
  logic [31:0] discrete_input;
  logic [7:0]  eq[$];
  logic [39:0] cases[$] = {40'h02_0000_0001, 40'h02_0005_001B, 40'h02_0000_0010,
    40'h02_0000_0021, 40'h02_0001_0020, 40'h03_0000_0001, 40'h03_0083_007D,
    40'h03_0000_007E, 40'h04_00C8_0039, 40'h04_0000_0000, 40'h04_00FF_0001,
    40'h01_0000_0001, 40'h06_0000_0001, 40'h05_0003_FF00, 40'h05_000F_FF00,
    40'h05_0003_0000, 40'h05_0003_1234, 40'h05_0010_FF00};
  int          error_cnt, checked;

  mbr_responder u_dut (.clk(clk), .sys_rst(sys_rst), .own_station(own_station),
    .rx_start(rx_start), .rx_valid(rx_valid), .rx_data(rx_data),
    .discrete_input(discrete_input), .word_rd_data(word_rd_data), .tx_ready(tx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .word_rd_en(word_rd_en),
    .word_rd_input(word_rd_input), .word_rd_addr(word_rd_addr),
    .coil_state(coil_state), .busy(busy));
  mbr_master u_m (.clk(clk), .rx_start(rx_start), .rx_valid(rx_valid), .rx_data(rx_data),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready));

  always #50 clk = ~clk;

  function automatic logic [15:0] wv(input logic inp, input logic [15:0] a);
    return a ^ (inp ? 16'hA55A : 16'h0F0F);
  endfunction
  // The word store answers one cycle after a fetch and scrambles otherwise.
  always @(posedge clk)
    word_rd_data <= word_rd_en ? wv(word_rd_input, word_rd_addr) : ~word_rd_data;

  function automatic logic [7:0] exc(input logic [7:0] f, input logic [15:0] a, n);
    if (f < 8'h02 || f > 8'h05) return 8'h01;
    if (f == 8'h05) return (n != 16'hFF00 && n != 16'h0000) ? 8'h03 : (a > 15 ? 8'h02 : 8'h00);
    if (n == 0 || n > (f == 8'h02 ? 32 : 125)) return 8'h03;
    return (a + n > (f == 8'h02 ? 32 : 256)) ? 8'h02 : 8'h00;
  endfunction

  task automatic fill(input logic [7:0] f, input logic [15:0] a, n);
    logic [7:0]  ex, b;
    logic [15:0] w;
    ex = exc(f, a, n);
    eq = {st, ex != 0 ? f | 8'h80 : f};
    if (ex != 0) eq.push_back(ex);
    else if (f == 8'h05) begin
      eq = {eq, a[15:8], a[7:0], n[15:8], n[7:0]};
      coil_e[a[3:0]] = n[15];
    end else if (f == 8'h02) begin
      eq.push_back(8'((n + 7) / 8));
      for (int k = 0; k < (n + 7) / 8; k++) begin
        for (int i = 0; i < 8; i++) b[i] = (8 * k + i < n) && discrete_input[a + 8 * k + i];
        eq.push_back(b);
      end
    end else begin
      eq.push_back(8'(2 * n));
      for (int j = 0; j < n; j++) begin
        w = wv(f == 8'h04, a + 16'(j));
        eq = {eq, w[15:8], w[7:0]};
      end
    end
  endtask

  task automatic chk(input string nm, input logic [15:0] s, e);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic run(input logic [7:0] s, f, input logic [15:0] a, n);
    logic [15:0] ev;
    u_m.rsp = {};
    discrete_input <= $urandom;
    u_m.send({s, f, a, n});
    eq = {};
    if (s == st || s == 8'h00) fill(f, a, n);
    if (s != st) eq = {};
    for (int t = 0; t < 3000 && (t < 4 || busy !== 1'b0); t++) @(posedge clk);
    // A reply still pending when the wait runs out counts as a mismatch.
    chk("idle", {15'h0000, busy}, 16'h0000);
    chk("length", 16'(u_m.rsp.size()), 16'(eq.size()));
    foreach (eq[i]) begin
      ev = {7'h00, i == eq.size() - 1, eq[i]};
      chk("byte", 16'(u_m.rsp[i]), ev);
    end
    chk("coil", coil_state, coil_e);
    $display("test fc %h station %h done", f, s);
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    own_station = 8'h00;
    discrete_input = 32'h0;
    word_rd_data = 16'h0;
    coil_e = 16'h0;
    st = 8'($urandom(41618));
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    st = 8'($urandom_range(247, 1));
    own_station <= st;
    foreach (cases[c]) run(st, cases[c][39:32], cases[c][31:16], cases[c][15:0]);
    run(st == 8'hF7 ? 8'h01 : st + 8'h01, 8'h05, 16'h0002, 16'hFF00);
    run(8'h00, 8'h05, 16'h0007, 16'hFF00);
    run(8'h00, 8'h03, 16'h0000, 16'h0001);
    // An own number outside the valid range must silence every reply.
    own_station <= 8'hF8;
    run(8'hF8, 8'h03, 16'h0000, 16'h0001);
    own_station <= st;
    repeat (25) begin
      u_m.slow = 1'($urandom_range(1));
      fc = 8'($urandom_range(6, 1));
      run(st, fc, 16'($urandom_range(40)), fc == 8'h05 ?
        {8'($urandom_range(1)) * 8'hFF, 8'h00} : 16'($urandom_range(40)));
    end
    give_verdict();
  end

  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end
endmodule // tb_top
